// ==== bench/suc_apb_mst.sv ====
// APB master model standing in for the probe or processor.
// Assumes a slave whose pready is sampled at rising edges.
`timescale 1ns/10ps
`default_nettype none
module suc_apb_mst (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
    o_pstrb = 4'h0;
  end
  // One transfer, lanes chosen by strobe, held until pready or at most 16 wait cycles
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rd, output logic err, output logic to);
    int n;
    n = 0;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= s;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge i_clk);
    end
    to = (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    // Released lines show a changed pattern, not the old value
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== bench/suc_chk.sv ====
// Checker for the service unit front end.
// Assumes it is bound to suc_service_unit.
`timescale 1ns/10ps
`default_nettype none
module suc_chk #(
  parameter AW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_guard_active,
  input wire logic i_result_valid,
  input wire logic [31:0] i_result_data,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic o_erase_start,
  input wire logic o_bist_start,
  input wire logic o_crc_start,
  input wire logic o_soft_reset,
  input wire logic [31:0] o_op_location,
  input wire logic [31:0] o_op_data
);
  logic acc;
  logic [AW-3:0] idx;
  logic cw;
  assign acc = i_psel & i_penable;
  assign idx = i_paddr[AW-1:2];
  // Accepted control write on lane 0
  assign cw = acc & i_pwrite & (idx == 0) & i_pstrb[0] & !i_guard_active;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_erase_pulse: assert property (cw && i_pwdata[4] && !i_pwdata[0] |=> o_erase_start)
    else $error("erase start missing");
  chk_zero_write: assert property (
    cw && i_pwdata[4:0] == 5'h00 |=> !(o_erase_start | o_bist_start | o_crc_start | o_soft_reset))
    else $error("zero write started something");
  chk_strobe_once: assert property (
    (o_erase_start | o_bist_start | o_crc_start) |=> !(o_erase_start | o_bist_start | o_crc_start))
    else $error("start longer than a cycle");
  chk_soft_pulse: assert property (cw && i_pwdata[0] |=> o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset pulse wrong");
  chk_loc_write: assert property (
    acc && i_pwrite && idx == 4 && i_pstrb == 4'hf && !i_guard_active
    |=> o_op_location == ($past(i_pwdata) & 32'hfffffffc))
    else $error("location write wrong");
  chk_guard_block: assert property (
    acc && i_pwrite && idx == 4 && i_guard_active |-> o_pslverr ##1 $stable(o_op_location))
    else $error("guarded write not refused");
  chk_ctrl_zero: assert property (acc && !i_pwrite && idx == 0 |-> o_prdata == 32'h0)
    else $error("control reads nonzero");
  chk_sta_resv: assert property (acc && !i_pwrite && idx == 1 |-> o_prdata[31:5] == 27'h0)
    else $error("status reserved bits set");
  chk_result_load: assert property (i_result_valid && !o_soft_reset |=> o_op_data == $past(i_result_data))
    else $error("result not loaded");
  cov_erase: cover property (o_erase_start);
  cov_soft: cover property (o_soft_reset);
  cov_guard: cover property (acc && i_guard_active && o_pslverr);
endmodule
bind suc_service_unit suc_chk #(.AW(AW)) u_chk (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .i_pstrb, .i_guard_active, .i_result_valid, .i_result_data, .o_pslverr, .o_prdata,
  .o_erase_start, .o_bist_start, .o_crc_start, .o_soft_reset, .o_op_location, .o_op_data);
`default_nettype wire

// ==== bench/suc_service_unit_tb_top.sv ====
// Self-checking bench for the service unit front end.
// Assumes the APB master model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module suc_service_unit_tb_top;
  logic clk, rst, guard, sec;
  logic [6:0] ev;
  logic [31:0] rdata, rdv;
  logic errv;
  int failures, checks_done;
  wire psel, pen, pwr, pready, pslverr, erase, bist, crc, srst;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata, loc, cnt, dat;
  wire [3:0] pstrb;
  suc_apb_mst u_mst (.i_clk(clk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
  suc_service_unit #(.AW(8)) dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_guard_active(guard), .i_secured_in(sec),
    .i_probe_detect(ev[0]), .i_cold_plug_detect(ev[1]), .i_clk_func_change(ev[2]),
    .i_op_done(ev[3]), .i_op_fail(ev[4]), .i_op_bus_err(ev[5]), .i_result_valid(ev[6]),
    .i_result_data(rdata), .o_erase_start(erase), .o_bist_start(bist), .o_crc_start(crc),
    .o_soft_reset(srst), .o_op_location(loc), .o_op_word_count(cnt), .o_op_data(dat));
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic to;
    u_mst.xfer(w, a, d, s, rdv, errv, to);
    if (to)
    begin
      failures++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    cmp(n, e, rdv);
  endtask
  // Event inputs high for one cycle
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h0;
  endtask
  // Control write, then start outputs {erase,bist,crc,soft}
  task automatic strobe(input logic [7:0] v, input logic [3:0] e);
    wr(8'h00, {24'h0, v});
    @(posedge clk);
    cmp("starts", {28'h0, e}, {28'h0, erase, bist, crc, srst});
    @(posedge clk);
    cmp("starts off", 32'h0, {28'h0, erase, bist, crc, srst});
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_reset;
    rd("ctrl", 8'h00, 32'h0);
    rd("sta", 8'h04, 32'h0);
    rd("stb", 8'h08, 32'h10);
    rd("loc", 8'h10, 32'h0);
    rd("cnt", 8'h20, 32'h0);
    rd("gap", 8'h0c, 32'h0);
    cmp("gap err", 32'h1, {31'h0, errv});
    $display("reset values done");
  endtask
  task automatic t_starts;
    strobe(8'h10, 4'h8);
    strobe(8'h08, 4'h4);
    strobe(8'h04, 4'h2);
    strobe(8'h00, 4'h0);
    rd("ctrl", 8'h00, 32'h0);
    $display("starts done");
  endtask
  task automatic t_status;
    pulse(7'h38);
    pulse(7'h02);
    rd("sta", 8'h04, 32'h0f);
    wr(8'h04, 32'h00);
    rd("sta w0", 8'h04, 32'h0f);
    wr(8'h04, 32'h05);
    rd("sta w1", 8'h04, 32'h0a);
    wr(8'h04, 32'h0a);
    rd("sta clr", 8'h04, 32'h00);
    @(posedge clk);
    rdata <= 32'h5a5aa5a5;
    pulse(7'h40);
    rd("data", 8'h30, 32'h5a5aa5a5);
    cmp("data port", 32'h5a5aa5a5, dat);
    $display("status done");
  endtask
  task automatic t_words;
    wr(8'h10, 32'hfffffffc);
    rd("loc", 8'h10, 32'hfffffffc);
    cmp("loc port", 32'hfffffffc, loc);
    bus(1'b1, 8'h20, 32'h0000ab00, 4'h2);
    bus(1'b1, 8'h20, 32'hcdef0003, 4'hc);
    rd("cnt lanes", 8'h20, 32'hcdefab00);
    cmp("cnt port", 32'hcdefab00, cnt);
    @(posedge clk);
    guard <= 1'b1;
    wr(8'h10, 32'h12345678);
    cmp("guard err", 32'h1, {31'h0, errv});
    @(posedge clk);
    guard <= 1'b0;
    rd("loc kept", 8'h10, 32'hfffffffc);
    $display("words done");
  endtask
  task automatic t_mbox;
    wr(8'h40, 32'h11112222);
    rd("stb d0", 8'h08, 32'h14);
    wr(8'h50, 32'h3);
    wr(8'h08, 32'h1f);
    rd("stb d1", 8'h08, 32'h1c);
    rd("mbx0", 8'h40, 32'h11112222);
    rd("stb rd", 8'h08, 32'h18);
    pulse(7'h01);
    pulse(7'h04);
    rd("stb probe", 8'h08, 32'h0a);
    strobe(8'h01, 4'h1);
    rd("stb srst", 8'h08, 32'h02);
    rd("loc srst", 8'h10, 32'h0);
    $display("mailbox done");
  endtask
  task automatic t_secure;
    @(posedge clk);
    sec <= 1'b1;
    do_reset();
    rd("stb sec", 8'h08, 32'h11);
    strobe(8'h08, 4'h0);
    strobe(8'h04, 4'h0);
    rd("sta deny", 8'h04, 32'h10);
    wr(8'h04, 32'h10);
    rd("sta clr", 8'h04, 32'h0);
    strobe(8'h10, 4'h8);
    $display("secured done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    guard = 1'b0;
    sec = 1'b0;
    ev = 7'h0;
    rdata = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_starts();
    t_status();
    t_words();
    t_mbox();
    t_secure();
    finish_test();
  end
endmodule
`default_nettype wire

// ==== core/suc_defines.vh ====
// Constants for the service unit control and status block.
// Assumes an APB slave with 32-bit data and one register word per index.
//
// Notes on behaviour
// - byte, halfword, word accesses each done atomically
// - every byte and halfword lane separately addressable
// - guarded registers refuse writes while guard active
// - control bit 4 one starts chip erase
// - control bit 3 one starts self-test
// - control bit 2 one starts CRC
// - control bit 0 one resets the unit
// - reserved bits read zero, master writes zero
// - status bit 4 sets on forbidden command
// - status bit 3 sets on failure, W1C
// - status bit 2 sets on bus error, W1C
// - status bit 1 sets on cold-plug, W1C
// - status bit 0 sets on completion, W1C
// - hot-plug flag resets one, clock change clears
// - mailbox dirty set on write, cleared on read
// - probe flag sets once, never clears
// - secured flag caught at power-up, never clears
// - start location bits 31:2, low bits zero
// - word count bits 31:2, low bits zero
// - data register gives seed, takes result
`ifndef SUC_DEFINES_VH
`define SUC_DEFINES_VH

// ---------------------------------------------------------------
// Register indices, byte address is four times the index
// ---------------------------------------------------------------
`define SUC_IDX_CTRL 8'h00
`define SUC_IDX_STA 8'h01
`define SUC_IDX_STB 8'h02
`define SUC_IDX_LOC 8'h04
`define SUC_IDX_LEN 8'h08
`define SUC_IDX_DATA 8'h0c
`define SUC_IDX_MBX0 8'h10
`define SUC_IDX_MBX1 8'h14
`define SUC_AW 8

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SUC_CTRL_ERASE 4
`define SUC_CTRL_BIST 3
`define SUC_CTRL_CRC 2
`define SUC_CTRL_SRST 0
`define SUC_STA_DENIED 4
`define SUC_STA_FAIL 3
`define SUC_STA_BUS_FAULT 2
`define SUC_STA_CRST 1
`define SUC_STA_DONE 0
`define SUC_STB_HOTPLUG 4
`define SUC_STB_DIRTY1 3
`define SUC_STB_DIRTY0 2
`define SUC_STB_PROBE 1
`define SUC_STB_SEC 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SUC_RST_FLAGS 5'h00
`define SUC_RST_WORD 32'h00000000
`define SUC_WORD_MASK 32'hfffffffc

`endif

// ==== core/suc_service_unit.v ====
// Service unit control and status register front end, APB slave.
// Assumes the erase, self-test and CRC engines and all event inputs
// run on i_clk; strobes and flags exchanged with them need no sync.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "suc_defines.vh"

module suc_service_unit #(
  parameter AW = `SUC_AW
) (
  input wire i_clk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [AW-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  // Chip context
  input wire i_guard_active,
  input wire i_secured_in,
  input wire i_probe_detect,
  input wire i_cold_plug_detect,
  input wire i_clk_func_change,
  // Engine side
  input wire i_op_done,
  input wire i_op_fail,
  input wire i_op_bus_err,
  input wire i_result_valid,
  input wire [31:0] i_result_data,
  output reg o_erase_start,
  output reg o_bist_start,
  output reg o_crc_start,
  output reg o_soft_reset,
  output reg [31:0] o_op_location,
  output reg [31:0] o_op_word_count,
  output reg [31:0] o_op_data
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg [4:0] sta_q; // Sticky status flags a
  reg [4:0] sta_d;
  reg hot_plug_q; // Hot-plug allowed
  reg [1:0] dirty_q; // Mailbox dirty flags
  reg [1:0] dirty_d;
  reg probe_q; // Probe attached
  reg sec_q; // Secured state
  reg sec_cap_q; // Pending power-up capture of secured state
  reg [31:0] mbx0_q; // Debug mailbox 0
  reg [31:0] mbx1_q; // Debug mailbox 1
  reg [31:0] rd_d; // Read data for the coming access phase
  wire [31:0] lane_m; // Byte lane write mask
  wire [7:0] idx; // Register index from byte address
  wire acc; // Access phase
  wire wr_any; // Write in access phase
  wire rd_any; // Read in access phase
  wire mapped; // Address hits a register
  wire guarded; // Address hits a write guarded register
  wire wr_ok; // Write that takes effect
  wire wr_blk; // Write refused by the guard
  wire ctrl_wr; // Accepted write to control lane 0
  wire sta_wr; // Accepted write to status a lane 0
  wire req_erase; // Erase request written
  wire req_bist; // Self-test request written
  wire req_crc; // CRC request written
  wire req_srst; // Unit reset request written
  wire deny; // Request refused in secured state

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign idx = {2'b00, i_paddr[AW-1:2]};
  assign acc = i_psel & i_penable;
  assign wr_any = acc & i_pwrite;
  assign rd_any = acc & ~i_pwrite;

  // Address map check, mailboxes are the only unguarded registers
  assign mapped = (idx == `SUC_IDX_CTRL) | (idx == `SUC_IDX_STA) |
                  (idx == `SUC_IDX_STB) | (idx == `SUC_IDX_LOC) |
                  (idx == `SUC_IDX_LEN) | (idx == `SUC_IDX_DATA) |
                  (idx == `SUC_IDX_MBX0) | (idx == `SUC_IDX_MBX1);
  assign guarded = mapped & (idx != `SUC_IDX_MBX0) & (idx != `SUC_IDX_MBX1);

  // Guarded writes are refused while the guard is on
  assign wr_blk = wr_any & guarded & i_guard_active;
  assign wr_ok = wr_any & mapped & ~wr_blk;

  // Zero wait slave, error on unmapped or refused access
  assign o_pready = 1'b1;
  assign o_pslverr = acc & (~mapped | wr_blk);

  // ---------------------------------------------------------------
  // Byte lane mask
  // ---------------------------------------------------------------
  // Each strobe opens its own byte, so byte and halfword writes
  // land in one cycle and touch nothing else
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign lane_m[g*8+7:g*8] = {8{i_pstrb[g]}};
    end
  endgenerate

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  assign ctrl_wr = wr_ok & (idx == `SUC_IDX_CTRL) & i_pstrb[0];
  assign sta_wr = wr_ok & (idx == `SUC_IDX_STA) & i_pstrb[0];
  assign req_erase = ctrl_wr & i_pwdata[`SUC_CTRL_ERASE];
  assign req_bist = ctrl_wr & i_pwdata[`SUC_CTRL_BIST];
  assign req_crc = ctrl_wr & i_pwdata[`SUC_CTRL_CRC];
  assign req_srst = ctrl_wr & i_pwdata[`SUC_CTRL_SRST];

  // Self-test and CRC would expose memory, so secured state bars them
  assign deny = sec_q & (req_bist | req_crc);

  // ---------------------------------------------------------------
  // Start strobes
  // ---------------------------------------------------------------
  // One-cycle pulses, nothing is kept in the control register
  always @(posedge i_clk)
  begin
    if (i_rst | o_soft_reset)
    begin
      o_erase_start <= 1'b0;
      o_bist_start <= 1'b0;
      o_crc_start <= 1'b0;
    end
    else
    begin
      o_erase_start <= req_erase & ~req_srst;
      o_bist_start <= req_bist & ~sec_q & ~req_srst;
      o_crc_start <= req_crc & ~sec_q & ~req_srst;
    end
  end

  // Unit reset pulse, clears the unit on the following edge
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_soft_reset <= 1'b0;
    end
    else
    begin
      o_soft_reset <= req_srst;
    end
  end

  // ---------------------------------------------------------------
  // Status flags a
  // ---------------------------------------------------------------
  // Write one clears, an event in the same cycle wins
  always @*
  begin
    sta_d = sta_q;
    if (sta_wr)
    begin
      sta_d = sta_q & ~i_pwdata[4:0];
    end
    if (deny)
    begin
      sta_d[`SUC_STA_DENIED] = 1'b1;
    end
    if (i_op_fail)
    begin
      sta_d[`SUC_STA_FAIL] = 1'b1;
    end
    if (i_op_bus_err)
    begin
      sta_d[`SUC_STA_BUS_FAULT] = 1'b1;
    end
    if (i_cold_plug_detect)
    begin
      sta_d[`SUC_STA_CRST] = 1'b1;
    end
    if (i_op_done)
    begin
      sta_d[`SUC_STA_DONE] = 1'b1;
    end
  end

  // Flag register
  always @(posedge i_clk)
  begin
    if (i_rst | o_soft_reset)
    begin
      sta_q <= `SUC_RST_FLAGS;
    end
    else
    begin
      sta_q <= sta_d;
    end
  end

  // ---------------------------------------------------------------
  // Status flags b
  // ---------------------------------------------------------------
  // Hot-plug permission only comes back through the chip reset
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      hot_plug_q <= 1'b1;
    end
    else if (i_clk_func_change)
    begin
      hot_plug_q <= 1'b0;
    end
  end

  // Probe and secured flags only ever set, unit reset leaves them
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      probe_q <= 1'b0;
      sec_q <= 1'b0;
      sec_cap_q <= 1'b1;
    end
    else
    begin
      probe_q <= probe_q | i_probe_detect;
      sec_cap_q <= 1'b0;
      sec_q <= sec_q | (sec_cap_q & i_secured_in);
    end
  end

  // Dirty flags, a mailbox write sets and a read clears
  always @*
  begin
    dirty_d = dirty_q;
    if (rd_any & (idx == `SUC_IDX_MBX0))
    begin
      dirty_d[0] = 1'b0;
    end
    if (rd_any & (idx == `SUC_IDX_MBX1))
    begin
      dirty_d[1] = 1'b0;
    end
    if (wr_ok & (idx == `SUC_IDX_MBX0))
    begin
      dirty_d[0] = 1'b1;
    end
    if (wr_ok & (idx == `SUC_IDX_MBX1))
    begin
      dirty_d[1] = 1'b1;
    end
  end

  // Dirty register
  always @(posedge i_clk)
  begin
    if (i_rst | o_soft_reset)
    begin
      dirty_q <= 2'b00;
    end
    else
    begin
      dirty_q <= dirty_d;
    end
  end

  // ---------------------------------------------------------------
  // Word registers
  // ---------------------------------------------------------------
  // Location, count and data take the written lanes only
  always @(posedge i_clk)
  begin
    if (i_rst | o_soft_reset)
    begin
      o_op_location <= `SUC_RST_WORD;
      o_op_word_count <= `SUC_RST_WORD;
      o_op_data <= `SUC_RST_WORD;
      mbx0_q <= `SUC_RST_WORD;
      mbx1_q <= `SUC_RST_WORD;
    end
    else
    begin
      if (wr_ok & (idx == `SUC_IDX_LOC))
      begin
        o_op_location <= ((o_op_location & ~lane_m) | (i_pwdata & lane_m))
                         & `SUC_WORD_MASK;
      end
      if (wr_ok & (idx == `SUC_IDX_LEN))
      begin
        o_op_word_count <= ((o_op_word_count & ~lane_m) | (i_pwdata & lane_m))
                           & `SUC_WORD_MASK;
      end
      // Engine result overrides a bus write in the same cycle
      if (i_result_valid)
      begin
        o_op_data <= i_result_data;
      end
      else if (wr_ok & (idx == `SUC_IDX_DATA))
      begin
        o_op_data <= (o_op_data & ~lane_m) | (i_pwdata & lane_m);
      end
      if (wr_ok & (idx == `SUC_IDX_MBX0))
      begin
        mbx0_q <= (mbx0_q & ~lane_m) | (i_pwdata & lane_m);
      end
      if (wr_ok & (idx == `SUC_IDX_MBX1))
      begin
        mbx1_q <= (mbx1_q & ~lane_m) | (i_pwdata & lane_m);
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read mux, reserved and unmapped bits read zero
  always @*
  begin
    rd_d = 32'h00000000;
    if (idx == `SUC_IDX_CTRL)
    begin
      rd_d = 32'h00000000;
    end
    else if (idx == `SUC_IDX_STA)
    begin
      rd_d = {27'h0000000, sta_q};
    end
    else if (idx == `SUC_IDX_STB)
    begin
      rd_d = {27'h0000000, hot_plug_q, dirty_q[1], dirty_q[0], probe_q, sec_q};
    end
    else if (idx == `SUC_IDX_LOC)
    begin
      rd_d = o_op_location;
    end
    else if (idx == `SUC_IDX_LEN)
    begin
      rd_d = o_op_word_count;
    end
    else if (idx == `SUC_IDX_DATA)
    begin
      rd_d = o_op_data;
    end
    else if (idx == `SUC_IDX_MBX0)
    begin
      rd_d = mbx0_q;
    end
    else if (idx == `SUC_IDX_MBX1)
    begin
      rd_d = mbx1_q;
    end
  end

  // Read data sampled in the setup cycle, valid for the access phase
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_prdata <= 32'h00000000;
    end
    else if (i_psel & ~i_penable & ~i_pwrite)
    begin
      o_prdata <= rd_d;
    end
  end

endmodule
`default_nettype wire
